// ---- lnt_regs.svh ----
`ifndef LNT_REGS_SVH
`define LNT_REGS_SVH

// ----------------------------------------------------------------
// clock and timer widths
// ----------------------------------------------------------------
`define LNT_CLK_MHZ 10
`define LNT_CNT_W 16
`define LNT_CNT_ZERO 16'h0000
`define LNT_CNT_ONE 16'h0001
`define LNT_CYC(us) ((us) * `LNT_CLK_MHZ)

// ----------------------------------------------------------------
// times in microseconds, except the pass-through count in cycles
// ----------------------------------------------------------------
`define LNT_DOM_TIMEOUT_US 6000
`define LNT_DOM_RELEASE_US 10
`define LNT_BUS_WAKE_US 90
`define LNT_LOCAL_WAKE_US 35
`define LNT_WAKE_REARM_US 6
`define LNT_MODE_ENTRY_US 10
`define LNT_PASS_CYC 1

// ----------------------------------------------------------------
// levels and reset values
// ----------------------------------------------------------------
`define LNT_ON 1'b1
`define LNT_OFF 1'b0
`define LNT_RECESSIVE 1'b1
`define LNT_DOMINANT 1'b0
`define LNT_HIGH 1'b1
`define LNT_LOW 1'b0

`endif

// ---- lnt_pkg.sv ----
`include "lnt_regs.svh"

package lnt_pkg;

   // one-hot operating modes
   typedef enum logic [2:0] {
      LNT_FAILSAFE = 3'h1,
      LNT_NORMAL = 3'h2,
      LNT_SLEEP = 3'h4
   } lnt_mode_t;

   // state of one pin filter
   typedef struct packed {
      logic [2:0] sync;
      logic agreed;
      logic filt;
      logic [`LNT_CNT_W-1:0] cnt;
   } lnt_deb_t;

   // state of the transceiver core
   typedef struct packed {
      lnt_mode_t mode;
      logic en_prev;
      logic bus_prev;
      logic wake_prev;
      logic [`LNT_CNT_W-1:0] dom_cnt;
      logic dom_lock;
      logic [`LNT_CNT_W-1:0] rel_cnt;
      logic [`LNT_CNT_W-1:0] rearm_cnt;
      logic wake_armed;
      logic wake_req;
      logic wake_local;
      logic bus_oe;
      logic rxd_oe;
      logic txd_oe;
      logic txd_strong;
      logic inhibit;
      logic term;
   } lnt_core_t;

endpackage

// ---- lnt_pin_filter.sv ----
`timescale 1ns/10ps
`include "lnt_regs.svh"

module lnt_pin_filter
   import lnt_pkg::*;
#(
   parameter logic [`LNT_CNT_W-1:0] THRESH = `LNT_CNT_ONE,
   parameter logic RST_LVL = `LNT_HIGH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic pin_in,
   output logic level_out,
   output logic filt_out
);

   lnt_deb_t s_q;
   lnt_deb_t s_d;

   // ----------------------------------------------------------------
   // synchroniser and debounce
   // ----------------------------------------------------------------

   // stage 0 is read only by stage 1; a change counts once stages 1 and 2 agree
   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], pin_in};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.agreed = s_q.sync[2];
      end
      // restart whenever the level returns before the threshold
      if (s_q.agreed == s_q.filt) begin
         s_d.cnt = `LNT_CNT_ZERO;
      end else if (s_q.cnt >= THRESH - `LNT_CNT_ONE) begin
         s_d.filt = s_q.agreed;
         s_d.cnt = `LNT_CNT_ZERO;
      end else begin
         s_d.cnt = s_q.cnt + `LNT_CNT_ONE;
      end
   end

   // clock enable low freezes the whole filter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '{sync: {3{RST_LVL}}, agreed: RST_LVL, filt: RST_LVL, cnt: `LNT_CNT_ZERO};
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.agreed;
   assign filt_out = s_q.filt;

endmodule

// ---- lnt_transceiver.sv ----
`timescale 1ns/10ps
`include "lnt_regs.svh"

// Summary of operation
// - undervoltage on the battery supply blocks every bus transmission
// - power-up lands in fail-safe with regulator inhibit switched on
// - normal mode: low transmit input drives bus dominant, high releases it
// - fail-safe mode: transmit pin becomes an output showing the wake source
// - transmit input has an internal pull-down, open input reads low
// - transmit low beyond dominant timeout forces driver off, bus recessive
// - timeout clears only after transmit held high beyond minimum release time
// - receive output open drain: in normal mode recessive bus reads high, dominant low
// - mode select high means normal mode with both paths active
// - mode select falling while transmit high enters sleep, transmit disabled
// - sleep drops bus termination, only weak pull-up current remains
// - mode select has internal pull-down, open input reads low and keeps the part out of normal
// - regulator inhibit on in normal, off and floating in sleep
// - qualified bus or local wake turns regulator inhibit on
// - wake from sleep goes to fail-safe; mode select high then gives normal
// - remote wake needs bus dominant for the bus wake debounce time
// - local wake needs wake pin low for the local wake debounce time
// - wake pin, bus and mode select each have their own debounce timer
// - sleep entry is accepted whatever the bus and wake pin levels
// - after a local wake the transmit pin gets a strong pull-down
// - after any wake the receive output is driven low as request
// - fail-safe shows remote wake as weak pull-down, local wake as strong
// - mode select high clears wake request and wake source together
// - new local wake needs wake pin high past minimum, then a fresh fall
module lnt_transceiver
   import lnt_pkg::*;
#(
   parameter logic [`LNT_CNT_W-1:0] DOM_TIMEOUT_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_DOM_TIMEOUT_US))
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic mode_select,
   input wire logic txd_in,
   output logic txd_out,
   output logic txd_oe,
   output logic txd_strong_pd,
   output logic txd_pulldown_on,
   input wire logic bus_in,
   output logic bus_out,
   output logic bus_oe,
   output logic termination_on,
   output logic rxd_out,
   output logic rxd_oe,
   input wire logic wake_in,
   output logic regulator_inhibit_out,
   output logic mode_pulldown_on,
   output logic [2:0] mode_state
);

   // ----------------------------------------------------------------
   // derived cycle counts
   // ----------------------------------------------------------------
   // every threshold counts cycles of the one fixed clock
   localparam logic [`LNT_CNT_W-1:0] DOM_RELEASE_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_DOM_RELEASE_US));
   localparam logic [`LNT_CNT_W-1:0] BUS_WAKE_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_BUS_WAKE_US));
   localparam logic [`LNT_CNT_W-1:0] LOCAL_WAKE_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_LOCAL_WAKE_US));
   localparam logic [`LNT_CNT_W-1:0] WAKE_REARM_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_WAKE_REARM_US));
   localparam logic [`LNT_CNT_W-1:0] MODE_ENTRY_CYC = `LNT_CNT_W'(`LNT_CYC(`LNT_MODE_ENTRY_US));
   localparam logic [`LNT_CNT_W-1:0] PASS_CYC = `LNT_CNT_W'(`LNT_PASS_CYC);

   // power-up state: fail-safe, inhibit and termination on, local wake armed
   // termination starts on so a freshly powered bus already sees its load
   localparam lnt_core_t CORE_RST = '{
      mode: LNT_FAILSAFE,
      en_prev: `LNT_LOW,
      bus_prev: `LNT_RECESSIVE,
      wake_prev: `LNT_HIGH,
      dom_cnt: `LNT_CNT_ZERO,
      dom_lock: `LNT_OFF,
      rel_cnt: `LNT_CNT_ZERO,
      rearm_cnt: `LNT_CNT_ZERO,
      wake_armed: `LNT_ON,
      wake_req: `LNT_OFF,
      wake_local: `LNT_OFF,
      bus_oe: `LNT_OFF,
      rxd_oe: `LNT_OFF,
      txd_oe: `LNT_OFF,
      txd_strong: `LNT_OFF,
      inhibit: `LNT_ON,
      term: `LNT_ON
   };

   // whole core state, registered in one place
   lnt_core_t s_q;
   lnt_core_t s_d;

   // synchronised and debounced pin levels
   logic supply_lvl;
   logic txd_lvl;
   logic en_filt;
   logic bus_lvl;
   logic bus_filt;
   logic wake_lvl;
   logic wake_filt;

   // ----------------------------------------------------------------
   // pin filters
   // ----------------------------------------------------------------

   // supply and transmit only need synchronising, no debounce
   // a one cycle threshold, since the three flops already settle the level
   lnt_pin_filter #(
      .THRESH(PASS_CYC),
      .RST_LVL(`LNT_LOW)
   ) u_supply (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(supply_ok),
      .level_out(),
      .filt_out(supply_lvl)
   );

   // transmit pin, read through its internal pull-down
   lnt_pin_filter #(
      .THRESH(PASS_CYC),
      .RST_LVL(`LNT_LOW)
   ) u_txd (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(txd_in),
      .level_out(),
      .filt_out(txd_lvl)
   );

   // each slow input has its own timer so a glitch on one cannot feed another
   // a short mode select glitch neither sleeps nor wakes the part
   lnt_pin_filter #(
      .THRESH(MODE_ENTRY_CYC),
      .RST_LVL(`LNT_LOW)
   ) u_en (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(mode_select),
      .level_out(),
      .filt_out(en_filt)
   );

   // bus filter: debounced edge qualifies a remote wake
   // the agreed level feeds the receive path, so data skips the wake timer
   lnt_pin_filter #(
      .THRESH(BUS_WAKE_CYC),
      .RST_LVL(`LNT_RECESSIVE)
   ) u_bus (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(bus_in),
      .level_out(bus_lvl),
      .filt_out(bus_filt)
   );

   // wake pin filter: debounced fall qualifies a local wake
   // the rise is debounced as well, so a bounce cannot fake a fresh fall
   lnt_pin_filter #(
      .THRESH(LOCAL_WAKE_CYC),
      .RST_LVL(`LNT_HIGH)
   ) u_wake (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_in(wake_in),
      .level_out(wake_lvl),
      .filt_out(wake_filt)
   );

   // ----------------------------------------------------------------
   // core next-state logic
   // ----------------------------------------------------------------

   // one pass builds the next state; later statements override earlier ones
   always_comb begin
      s_d = s_q;
      // previous filtered levels, kept for edge detection
      s_d.en_prev = en_filt;
      s_d.bus_prev = bus_filt;
      s_d.wake_prev = wake_filt;

      // dominant timeout counts only while the driver would be active
      // the count stops at the threshold, so a stuck low cannot wrap it
      if (s_q.mode == LNT_NORMAL && txd_lvl == `LNT_DOMINANT) begin
         if (s_q.dom_cnt >= DOM_TIMEOUT_CYC) begin
            s_d.dom_lock = `LNT_ON;
         end else begin
            s_d.dom_cnt = s_q.dom_cnt + `LNT_CNT_ONE;
         end
      end else begin
         s_d.dom_cnt = `LNT_CNT_ZERO;
      end

      // release needs transmit high beyond the minimum, any dip restarts it
      // the lock clears in any mode, so a later return to normal starts clean
      if (txd_lvl == `LNT_RECESSIVE && s_q.dom_lock) begin
         if (s_q.rel_cnt >= DOM_RELEASE_CYC) begin
            s_d.dom_lock = `LNT_OFF;
            s_d.rel_cnt = `LNT_CNT_ZERO;
         end else begin
            s_d.rel_cnt = s_q.rel_cnt + `LNT_CNT_ONE;
         end
      end else begin
         s_d.rel_cnt = `LNT_CNT_ZERO;
      end

      // re-arm local wake after the pin stays high past the minimum
      // the count saturates and the arm then stays set while the pin is high
      if (wake_lvl == `LNT_HIGH) begin
         if (s_q.rearm_cnt >= WAKE_REARM_CYC) begin
            s_d.wake_armed = `LNT_ON;
         end else begin
            s_d.rearm_cnt = s_q.rearm_cnt + `LNT_CNT_ONE;
         end
      end else begin
         s_d.rearm_cnt = `LNT_CNT_ZERO;
      end

      // a qualified fall consumes the arm whatever the mode, so a stuck low
      // pin cannot wake the part again after it is sent back to sleep
      if (s_q.wake_prev == `LNT_HIGH && wake_filt == `LNT_LOW) begin
         s_d.wake_armed = `LNT_OFF;
      end

      // mode sequencing
      // falling mode select with transmit still dominant is refused as sleep
      case (s_q.mode)
         LNT_NORMAL: begin
            if (s_q.en_prev == `LNT_HIGH && en_filt == `LNT_LOW) begin
               // sleep only with transmit already recessive; bus and wake ignored
               if (txd_lvl == `LNT_RECESSIVE) begin
                  s_d.mode = LNT_SLEEP;
               end else begin
                  // better a driverless fail-safe than a sleep with the bus held low
                  s_d.mode = LNT_FAILSAFE;
               end
            end
         end
         LNT_SLEEP: begin
            // local wake is tested after mode select but before the bus, and wins a tie with the bus
            if (en_filt == `LNT_HIGH) begin
               s_d.mode = LNT_NORMAL;
            end else if (s_q.wake_prev == `LNT_HIGH && wake_filt == `LNT_LOW && s_q.wake_armed) begin
               s_d.mode = LNT_FAILSAFE;
               s_d.wake_req = `LNT_ON;
               s_d.wake_local = `LNT_ON;
            end else if (s_q.bus_prev == `LNT_RECESSIVE && bus_filt == `LNT_DOMINANT) begin
               s_d.mode = LNT_FAILSAFE;
               s_d.wake_req = `LNT_ON;
               s_d.wake_local = `LNT_OFF;
            end else if (supply_lvl == `LNT_LOW) begin
               // undervoltage also leaves sleep, without a wake request
               // the regulator comes back on, yet the controller sees no request
               s_d.mode = LNT_FAILSAFE;
            end
         end
         default: begin
            // fail-safe waits for the controller to raise mode select
            // the bus driver stays off here whatever transmit shows
            if (en_filt == `LNT_HIGH) begin
               s_d.mode = LNT_NORMAL;
            end
         end
      endcase

      // mode select high wipes both wake flags in the same cycle
      // placed last so it beats every transition above
      if (en_filt == `LNT_HIGH) begin
         s_d.mode = LNT_NORMAL;
         s_d.wake_req = `LNT_OFF;
         s_d.wake_local = `LNT_OFF;
      end

      // bus driver: normal only, supply good, no timeout lock
      // next mode and next lock are used, so the driver drops on the same edge
      s_d.bus_oe = (s_d.mode == LNT_NORMAL) && supply_lvl && !s_d.dom_lock
                   && (txd_lvl == `LNT_DOMINANT);

      // receive path by mode
      // follows the agreed level, not the slow wake filter
      case (s_d.mode)
         LNT_NORMAL: begin
            s_d.rxd_oe = (bus_lvl == `LNT_DOMINANT);
         end
         LNT_FAILSAFE: begin
            s_d.rxd_oe = s_d.wake_req;
         end
         default: begin
            s_d.rxd_oe = `LNT_OFF; // high ohmic in sleep
         end
      endcase

      // wake source on the transmit pin, fail-safe only
      s_d.txd_oe = (s_d.mode == LNT_FAILSAFE) && s_d.wake_req;
      s_d.txd_strong = s_d.txd_oe && s_d.wake_local;

      // inhibit and termination follow the mode; wake leaves sleep so both come on
      // no separate wake term: every qualified wake lands in fail-safe
      s_d.inhibit = (s_d.mode != LNT_SLEEP);
      s_d.term = (s_d.mode != LNT_SLEEP);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   // asynchronous reset is the supply power-up
   // clock enable low holds every timer, flag and the mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= CORE_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // open-drain pins only ever pull low; the enables carry the data
   // every output is a flop or a constant, with no decode after it
   assign bus_out = `LNT_DOMINANT;
   assign bus_oe = s_q.bus_oe;
   assign rxd_out = `LNT_DOMINANT;
   assign rxd_oe = s_q.rxd_oe;
   // transmit pin output: only ever a pull-down, strength on its own flop
   assign txd_out = `LNT_LOW;
   assign txd_oe = s_q.txd_oe;
   assign txd_strong_pd = s_q.txd_strong;
   assign termination_on = s_q.term;
   assign regulator_inhibit_out = s_q.inhibit;
   assign mode_state = s_q.mode;

   // input pull-downs are always present
   // passive, so they act while reset is still held
   assign txd_pulldown_on = `LNT_ON;
   assign mode_pulldown_on = `LNT_ON;

endmodule

// ---- lnt_transceiver_props.sv ----
`timescale 1ns/10ps
`include "lnt_regs.svh"

// ------
// port checker
// ------
module lnt_transceiver_props #(
   parameter logic [`LNT_CNT_W-1:0] DOM_TIMEOUT_CYC = 16'h00C8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic supply_ok,
   input wire logic mode_select,
   input wire logic txd_in,
   input wire logic bus_oe,
   input wire logic txd_oe,
   input wire logic termination_on,
   input wire logic regulator_inhibit_out,
   input wire logic [2:0] mode_state
);
   localparam int SLEEP_MIN = 100;
   logic [15:0] dom_q;
   logic [15:0] dom_d;
   logic [15:0] lo_q;
   logic [15:0] lo_d;

   // run lengths: txd low while normal, mode select low
   always_comb begin
      dom_d = (!txd_in && mode_state == 3'h2) ? dom_q + 16'h0001 : 16'h0000;
      lo_d = mode_select ? 16'h0000 : lo_q + 16'h0001;
   end

   // runs are short, so no saturation is needed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dom_q <= 16'h0000;
         lo_q <= 16'h0000;
      end else begin
         dom_q <= dom_d;
         lo_q <= lo_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_into_sleep;
      mode_state != 3'h4 ##1 mode_state == 3'h4;
   endsequence
   sequence s_into_normal;
      mode_state != 3'h2 ##1 mode_state == 3'h2;
   endsequence
   sequence s_wake_exit;
      mode_state == 3'h4 ##1 mode_state == 3'h1;
   endsequence

   property p_drive_normal_only;
      bus_oe |-> mode_state == 3'h2;
   endproperty
   a_drive_normal_only: assert property (p_drive_normal_only) else $error("bus driven outside normal");
   property p_sleep_outputs;
      mode_state == 3'h4 |-> !regulator_inhibit_out && !termination_on && !bus_oe;
   endproperty
   a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong");
   property p_supply_block;
      !supply_ok [*7] |-> !bus_oe;
   endproperty
   a_supply_block: assert property (p_supply_block) else $error("drive with low supply");
   property p_txd_release;
      txd_in [*7] |-> !bus_oe;
   endproperty
   a_txd_release: assert property (p_txd_release) else $error("drive with txd high");
   property p_dom_timeout;
      dom_q > DOM_TIMEOUT_CYC + 16'h000A |-> !bus_oe;
   endproperty
   a_dom_timeout: assert property (p_dom_timeout) else $error("dominant not timed out");
   property p_wake_exit;
      s_wake_exit |-> regulator_inhibit_out && termination_on;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("wake exit outputs wrong");
   property p_src_failsafe;
      txd_oe |-> mode_state == 3'h1;
   endproperty
   a_src_failsafe: assert property (p_src_failsafe) else $error("txd driven outside fail-safe");
   property p_clear_on_normal;
      s_into_normal |-> !txd_oe && regulator_inhibit_out;
   endproperty
   a_clear_on_normal: assert property (p_clear_on_normal) else $error("flags kept in normal");
   property p_sleep_debounce;
      s_into_sleep |-> lo_q >= SLEEP_MIN && $past(txd_in, 100);
   endproperty
   a_sleep_debounce: assert property (p_sleep_debounce) else $error("sleep entry too early");
endmodule

// ---- lnt_far_side_model.sv ----
`timescale 1ns/10ps

// ------
// controller and remote node levels
// ------
module lnt_far_side_model (
   input wire logic ctl_low,
   input wire logic remote_dom,
   input wire logic txd_out,
   input wire logic txd_oe,
   input wire logic txd_strong_pd,
   input wire logic bus_out,
   input wire logic bus_oe,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output logic txd_level,
   output logic bus_level,
   output logic rxd_level
);
   // controller pulls low for dominant, else its pull-up wins
   // weak device pull-down loses to that pull-up, strong one wins
   assign txd_level = (txd_oe && txd_strong_pd) ? txd_out : !ctl_low;
   // wired-and bus with pull-up; a remote node may hold it dominant
   assign bus_level = !(bus_oe && !bus_out) && !remote_dom;
   // open-drain receive line, pull-up when released
   assign rxd_level = rxd_oe ? rxd_out : 1'b1;
endmodule

// ---- test_lnt_transceiver.sv ----
`timescale 1ns/10ps

module test_lnt_transceiver
   import lnt_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic supply_ok = 1'b1;
   logic mode_select = 1'b0;
   logic wake_in = 1'b1;
   logic ctl_low = 1'b0;
   logic remote_dom = 1'b0;
   logic clk_en = 1'b1;
   logic txd_out, txd_oe, txd_strong_pd, txd_pulldown_on, bus_out, bus_oe, termination_on;
   logic rxd_out, rxd_oe, regulator_inhibit_out, mode_pulldown_on, txd_level, bus_level, rxd_level;
   logic [2:0] mode_state;
   int err_total = 0;
   int n_checks = 0;

   always #50 clk = ~clk;

   // short dominant timeout keeps the run brief
   lnt_transceiver #(.DOM_TIMEOUT_CYC(16'h00C8)) u_lnt_transceiver (
      .clk(clk), .reset(reset), .clk_en(clk_en), .supply_ok(supply_ok), .mode_select(mode_select),
      .txd_in(txd_level), .txd_out(txd_out), .txd_oe(txd_oe), .txd_strong_pd(txd_strong_pd),
      .txd_pulldown_on(txd_pulldown_on), .bus_in(bus_level), .bus_out(bus_out), .bus_oe(bus_oe),
      .termination_on(termination_on), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .wake_in(wake_in),
      .regulator_inhibit_out(regulator_inhibit_out), .mode_pulldown_on(mode_pulldown_on),
      .mode_state(mode_state));

   lnt_far_side_model u_lnt_far_side_model (
      .ctl_low(ctl_low), .remote_dom(remote_dom), .txd_out(txd_out), .txd_oe(txd_oe),
      .txd_strong_pd(txd_strong_pd), .bus_out(bus_out), .bus_oe(bus_oe), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .txd_level(txd_level), .bus_level(bus_level), .rxd_level(rxd_level));

   // ------
   // helpers
   // ------
   // checks land on falling edges, well clear of register updates
   task automatic run(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_mode(input logic [2:0] exp);
      n_checks++;
      if (mode_state !== exp) begin
         err_total++;
         $display("wrong value mode_state expected %b seen %b", exp, mode_state);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ------
   // scenarios
   // ------
   task automatic t_power_up;
      run(1);
      chk_mode(LNT_FAILSAFE);
      chk_bit("inhibit", 1'b1, regulator_inhibit_out);
      chk_bit("pulldowns", 1'b1, txd_pulldown_on & mode_pulldown_on);
      @(posedge clk) ctl_low <= 1'b1;
      run(20);
      chk_bit("bus_oe", 1'b0, bus_oe);
      @(posedge clk) ctl_low <= 1'b0;
      $display("test power_up done");
   endtask

   task automatic t_normal;
      @(posedge clk) mode_select <= 1'b1;
      run(120);
      chk_mode(LNT_NORMAL);
      chk_bit("inhibit", 1'b1, regulator_inhibit_out);
      @(posedge clk) ctl_low <= 1'b1;
      run(15);
      chk_bit("bus_oe", 1'b1, bus_oe);
      chk_bit("rxd", 1'b0, rxd_level);
      @(posedge clk) supply_ok <= 1'b0;
      run(8);
      chk_bit("bus_oe", 1'b0, bus_oe);
      @(posedge clk) supply_ok <= 1'b1;
      ctl_low <= 1'b0;
      run(15);
      chk_bit("rxd", 1'b1, rxd_level);
      $display("test normal done");
   endtask

   // clock enable low must hold the driver off while transmit goes dominant
   task automatic t_freeze;
      @(posedge clk) clk_en <= 1'b0;
      ctl_low <= 1'b1;
      run(20);
      chk_bit("bus_oe frozen", 1'b0, bus_oe);
      chk_mode(LNT_NORMAL);
      @(posedge clk) ctl_low <= 1'b0;
      @(posedge clk) clk_en <= 1'b1;
      run(10);
      chk_bit("bus_oe", 1'b0, bus_oe);
      $display("test freeze done");
   endtask

   task automatic t_dom_timeout;
      @(posedge clk) ctl_low <= 1'b1;
      run(260);
      chk_bit("bus", 1'b1, bus_level);
      @(posedge clk) ctl_low <= 1'b0;
      run(50);
      @(posedge clk) ctl_low <= 1'b1;
      run(10);
      chk_bit("bus_oe", 1'b0, bus_oe);
      @(posedge clk) ctl_low <= 1'b0;
      run(150);
      @(posedge clk) ctl_low <= 1'b1;
      run(10);
      chk_bit("bus_oe", 1'b1, bus_oe);
      @(posedge clk) ctl_low <= 1'b0;
      $display("test dom_timeout done");
   endtask

   task automatic t_remote_wake;
      @(posedge clk) mode_select <= 1'b0;
      run(120);
      chk_mode(LNT_SLEEP);
      chk_bit("termination", 1'b0, termination_on);
      @(posedge clk) remote_dom <= 1'b1;
      run(300);
      @(posedge clk) remote_dom <= 1'b0;
      run(20);
      chk_mode(LNT_SLEEP);
      @(posedge clk) remote_dom <= 1'b1;
      run(950);
      chk_mode(LNT_FAILSAFE);
      chk_bit("inhibit", 1'b1, regulator_inhibit_out);
      chk_bit("rxd", 1'b0, rxd_level);
      chk_bit("txd", 1'b1, txd_level);
      @(posedge clk) remote_dom <= 1'b0;
      mode_select <= 1'b1;
      run(120);
      chk_mode(LNT_NORMAL);
      chk_bit("txd_oe", 1'b0, txd_oe);
      $display("test remote_wake done");
   endtask

   task automatic t_local_wake;
      @(posedge clk) mode_select <= 1'b0;
      run(120);
      @(posedge clk) wake_in <= 1'b0;
      run(200);
      @(posedge clk) wake_in <= 1'b1;
      run(30);
      chk_mode(LNT_SLEEP);
      @(posedge clk) wake_in <= 1'b0;
      run(400);
      chk_mode(LNT_FAILSAFE);
      chk_bit("txd", 1'b0, txd_level);
      chk_bit("rxd", 1'b0, rxd_level);
      @(posedge clk) mode_select <= 1'b1;
      run(120);
      chk_bit("strong", 1'b0, txd_strong_pd);
      @(posedge clk) mode_select <= 1'b0;
      run(120);
      chk_mode(LNT_SLEEP);
      run(400);
      chk_mode(LNT_SLEEP);
      @(posedge clk) wake_in <= 1'b1;
      run(420);
      @(posedge clk) wake_in <= 1'b0;
      run(400);
      chk_bit("strong", 1'b1, txd_strong_pd);
      $display("test local_wake done");
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_power_up();
      t_normal();
      t_freeze();
      t_dom_timeout();
      t_remote_wake();
      t_local_wake();
      finish_test();
   end

   // about 4500 cycles are expected; allow 10000
   initial begin
      #1000000;
      err_total++;
      $display("watchdog expired");
      finish_test();
   end
endmodule

bind lnt_transceiver lnt_transceiver_props #(.DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) u_lnt_transceiver_props (
   .clk(clk), .reset(reset), .supply_ok(supply_ok), .mode_select(mode_select), .txd_in(txd_in),
   .bus_oe(bus_oe), .txd_oe(txd_oe), .termination_on(termination_on),
   .regulator_inhibit_out(regulator_inhibit_out), .mode_state(mode_state));
